// >>> logic/decpin_counter.sv
/*
 One 40-bit event counter with its increment and overflow detection.
 Assumes the control fields are already decoded by the parent and that
 software writes arrive as single-cycle strobes.
*/
`timescale 1ns/1ps
module decpin_counter
   import decpin_pkg::*;
#(
   parameter int width = counter_width
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst_n,
   // Decoded control
   input  wire logic [2:0]       count_control,
   input  wire logic [1:0]       current_privilege_level,
   // Event inputs from the core
   input  wire logic [1:0]       occurrences,
   input  wire logic             condition,
   // Software write
   input  wire logic             load,
   input  wire logic [width-1:0] load_value,
   // Results
   output logic [width-1:0]      count,
   output logic                  incremented,
   output logic                  overflowed
);
   logic             privilege_ok;
   logic [1:0]       step;
   logic [width:0]   sum;

   always_comb begin
      privilege_ok = (current_privilege_level == user_privilege) ?
                     count_control[control_user_bit] :
                     count_control[control_super_bit];
      if (!privilege_ok) begin
         step = 2'h0;
      end else if (count_control[control_clock_bit]) begin
         step = {1'b0, condition};
      end else begin
         step = occurrences;
      end
      sum = {1'b0, count} + {{(width-1){1'b0}}, step};
   end

   // Wraps on carry and keeps counting under the same code
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         count <= '0;
      end else if (load) begin
         count <= load_value;
      end else begin
         count <= sum[width-1:0];
      end
   end

   // Write wins over the event in the same clock, so no flag then
   // Flags stay combinational so the parent owns the whole pin lag
   assign incremented = !load && (step != 2'h0);
   assign overflowed  = !load && sum[width];
endmodule

// >>> logic/decpin_pkg.sv
/*
 Package for the dual event counter with indicator pins: control field
 layout, control codes, register selects and pin timing.
 Assumes nothing of its surroundings.
*/
package decpin_pkg;
   localparam int counter_width       = 40;
   localparam int control_width       = 32;
   localparam int write_width         = 64;
   localparam int event_code_width    = 6;
   localparam int count_control_width = 3;

   // Field positions in counter_control_select
   localparam int event_code_zero_lsb    = 0;
   localparam int count_control_zero_lsb = 6;
   localparam int pin_function_zero_bit  = 9;
   localparam int event_code_one_lsb     = 16;
   localparam int count_control_one_lsb  = 22;
   localparam int pin_function_one_bit   = 25;

   // Bits inside a count control field
   localparam int control_clock_bit = 2;
   localparam int control_user_bit  = 1;
   localparam int control_super_bit = 0;

   localparam logic [control_width-1:0] control_reset = 32'h0000_0000;
   localparam logic [counter_width-1:0] counter_reset = 40'h00_0000_0000;

   // Register selects for model_register_read / model_register_write
   localparam logic [1:0] select_control     = 2'h0;
   localparam logic [1:0] select_counter_zero = 2'h1;
   localparam logic [1:0] select_counter_one  = 2'h2;

   localparam logic [1:0] user_privilege = 2'h3;
   localparam logic [1:0] top_privilege  = 2'h0;

   // Total pin lag in clocks from the internal event
   localparam int pin_lag_clocks = 5;

   // Per-counter indication state seen at the pin
   typedef enum logic [1:0] {
      pin_idle,
      pin_increment,
      pin_overflow,
      pin_breakpoint
   } decpin_pin_type;
endpackage

// >>> logic/decpin_top.sv
/*
 Dual 40-bit event counter with two external indicator pins.
 Holds the control register, both counters, the privileged register
 access port and the delayed pin drive.
 Assumes register accesses arrive as one-cycle strobes from the core,
 together with the requester's privilege level, and that event inputs
 are synchronous to clock.
*/
`timescale 1ns/1ps
module decpin_top
   import decpin_pkg::*;
#(
   parameter int lag = pin_lag_clocks
) (
   // Clock and reset
   input  wire logic                     clock,
   input  wire logic                     rst_n,
   // Core state
   input  wire logic [1:0]               current_privilege_level,
   // Register access port
   input  wire logic                     model_register_read,
   input  wire logic                     model_register_write,
   input  wire logic [1:0]               register_select,
   input  wire logic [write_width-1:0]   write_data,
   output logic      [write_width-1:0]   read_data,
   output logic                          read_valid,
   output logic                          access_fault,
   // Events from the core, one group per counter plus the shared event_lines
   input  wire logic [1:0]               occurrences_zero,
   input  wire logic [1:0]               occurrences_one,
   input  wire logic [63:0]              condition_zero_bus,
   input  wire logic [63:0]              condition_one_bus,
   input  wire logic [63:0]              event_lines,
   // Debug takeover of the pins
   input  wire logic                     breakpoint_mode,
   input  wire logic [1:0]               breakpoint_match,
   // Indicator pins
   output logic                          indicator_pin_zero,
   output logic                          indicator_pin_one,
   output logic      [control_width-1:0] control_view
);
   logic [control_width-1:0] counter_control_select;
   logic [counter_width-1:0] event_counter_zero;
   logic [counter_width-1:0] event_counter_one;
   logic [event_code_width-1:0]    event_code_zero;
   logic [event_code_width-1:0]    event_code_one;
   logic [count_control_width-1:0] count_control_zero;
   logic [count_control_width-1:0] count_control_one;
   logic                     pin_function_zero;
   logic                     pin_function_one;
   logic                     privileged;
   logic                     load_zero;
   logic                     load_one;
   logic [1:0]               occ_zero_sel;
   logic [1:0]               occ_one_sel;
   logic                     cond_zero_sel;
   logic                     cond_one_sel;
   logic                     inc_zero;
   logic                     inc_one;
   logic                     ovf_zero;
   logic                     ovf_one;
   logic [lag-2:0]           stage_zero;
   logic [lag-2:0]           stage_one;
   decpin_pin_type           mode_zero;
   decpin_pin_type           mode_one;

   assign event_code_zero    = counter_control_select[event_code_zero_lsb +: event_code_width];
   assign event_code_one     = counter_control_select[event_code_one_lsb +: event_code_width];
   assign count_control_zero =
      counter_control_select[count_control_zero_lsb +: count_control_width];
   assign count_control_one  =
      counter_control_select[count_control_one_lsb +: count_control_width];
   assign pin_function_zero  = counter_control_select[pin_function_zero_bit];
   assign pin_function_one   = counter_control_select[pin_function_one_bit];

   assign privileged = (current_privilege_level == top_privilege);
   assign load_zero  = model_register_write && privileged &&
                       (register_select == select_counter_zero);
   assign load_one   = model_register_write && privileged &&
                       (register_select == select_counter_one);

   // Event code steers which core line feeds each counter
   always_comb begin
      cond_zero_sel = condition_zero_bus[event_code_zero];
      cond_one_sel  = condition_one_bus[event_code_one];
      occ_zero_sel  = event_lines[event_code_zero] ? occurrences_zero : 2'h0;
      occ_one_sel   = event_lines[event_code_one] ? occurrences_one : 2'h0;
   end

   // Control register: whole-word writes only
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         counter_control_select <= control_reset;
      end else if (model_register_write && privileged &&
                   register_select == select_control) begin
         counter_control_select <= write_data[control_width-1:0];
      end
   end

   decpin_counter #(
      .width (counter_width)
   ) u_counter_zero (
      .clock                   (clock),
      .rst_n                   (rst_n),
      .count_control           (count_control_zero),
      .current_privilege_level (current_privilege_level),
      .occurrences             (occ_zero_sel),
      .condition               (cond_zero_sel),
      .load                    (load_zero),
      .load_value              (write_data[counter_width-1:0]),
      .count                   (event_counter_zero),
      .incremented             (inc_zero),
      .overflowed              (ovf_zero)
   );

   decpin_counter #(
      .width (counter_width)
   ) u_counter_one (
      .clock                   (clock),
      .rst_n                   (rst_n),
      .count_control           (count_control_one),
      .current_privilege_level (current_privilege_level),
      .occurrences             (occ_one_sel),
      .condition               (cond_one_sel),
      .load                    (load_one),
      .load_value              (write_data[counter_width-1:0]),
      .count                   (event_counter_one),
      .incremented             (inc_one),
      .overflowed              (ovf_one)
   );

   // Read path samples the running counters without stopping them
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         read_data    <= '0;
         read_valid   <= 1'b0;
         access_fault <= 1'b0;
      end else begin
         read_valid   <= model_register_read && privileged;
         access_fault <= (model_register_read || model_register_write) && !privileged;
         if (model_register_read && privileged) begin
            case (register_select)
               select_control:      read_data <= {32'h0000_0000, counter_control_select};
               select_counter_zero: read_data <= {24'h00_0000, event_counter_zero};
               select_counter_one:  read_data <= {24'h00_0000, event_counter_one};
               default:             read_data <= '0;
            endcase
         end
      end
   end

   // Indication source per pin: breakpoint takeover beats counting
   always_comb begin
      if (breakpoint_mode) begin
         mode_zero = pin_breakpoint;
         mode_one  = pin_breakpoint;
      end else begin
         mode_zero = pin_function_zero ? pin_overflow : pin_increment;
         mode_one  = pin_function_one ? pin_overflow : pin_increment;
      end
   end

   // Flags come in the event clock; lag-1 stages, then the pin flop
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stage_zero <= '0;
         stage_one  <= '0;
      end else begin
         case (mode_zero)
            pin_overflow:   stage_zero[0] <= ovf_zero;
            pin_increment:  stage_zero[0] <= inc_zero;
            pin_breakpoint: stage_zero[0] <= breakpoint_match[0];
            default:        stage_zero[0] <= 1'b0;
         endcase
         case (mode_one)
            pin_overflow:   stage_one[0] <= ovf_one;
            pin_increment:  stage_one[0] <= inc_one;
            pin_breakpoint: stage_one[0] <= breakpoint_match[1];
            default:        stage_one[0] <= 1'b0;
         endcase
         for (int i = 1; i < lag - 1; i++) begin
            stage_zero[i] <= stage_zero[i-1];
            stage_one[i]  <= stage_one[i-1];
         end
      end
   end

   // Pins lag the internal event by lag clocks in total
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         indicator_pin_zero <= 1'b0;
         indicator_pin_one  <= 1'b0;
         control_view       <= control_reset;
      end else begin
         indicator_pin_zero <= stage_zero[lag-2];
         indicator_pin_one  <= stage_one[lag-2];
         control_view       <= counter_control_select;
      end
   end
endmodule

// >>> test/decpin_chk.sv
/* Port checker for decpin_top: register port, counting and pins.
   Assumes the bind below and a single clock domain. */
`timescale 1ns/1ps
module decpin_chk
   import decpin_pkg::*;
#(
   parameter int lag = pin_lag_clocks
) (
   // Clock and reset
   input wire logic                     clock,
   input wire logic                     rst_n,
   // Register port
   input wire logic [1:0]               current_privilege_level,
   input wire logic                     model_register_read,
   input wire logic                     model_register_write,
   input wire logic [1:0]               register_select,
   input wire logic [write_width-1:0]   write_data,
   input wire logic                     read_valid,
   input wire logic                     access_fault,
   // Events and pins
   input wire logic [1:0]               occurrences_zero,
   input wire logic [63:0]              event_lines,
   input wire logic                     breakpoint_mode,
   input wire logic                     indicator_pin_zero,
   input wire logic                     indicator_pin_one,
   input wire logic [control_width-1:0] control_view
);
   logic ok;
   assign ok = current_privilege_level == top_privilege;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   AST_RESET: assert property ($rose(rst_n) |-> control_view == control_reset)
      else $error("control not clear after reset");
   AST_FAULT: assert property ((model_register_read || model_register_write) && !ok
      |=> access_fault && !read_valid) else $error("refused access not flagged");
   AST_READ: assert property (model_register_read && ok |=> read_valid && !access_fault)
      else $error("read not answered");
   AST_CTRL_WR: assert property (model_register_write && ok
      && register_select == select_control
      |=> ##1 control_view == control_width'($past(write_data, 2)))
      else $error("control write lost");
   AST_BAD_WR: assert property (model_register_write && !ok |=> ##1 $stable(control_view))
      else $error("refused write changed control");
   AST_OFF: assert property ((control_view[7:6] == 2'h0 && !breakpoint_mode)[*7]
      |-> !indicator_pin_zero) else $error("disabled counter drove pin");
   AST_INC: assert property (!breakpoint_mode && control_view[9:6] == 4'h3
      && occurrences_zero != 2'h0 && event_lines[control_view[5:0]]
      && !(model_register_write && ok && register_select == select_counter_zero)
      ##1 $stable(control_view)
      |-> ##(lag-1) (indicator_pin_zero || breakpoint_mode)) else $error("increment pin missing");
   AST_OVF: assert property ((control_view[9] && !breakpoint_mode)[*4]
      ##0 indicator_pin_zero
      |=> !indicator_pin_zero || breakpoint_mode) else $error("overflow pin too long");

   cover property (control_view[9] && indicator_pin_zero);
   cover property (access_fault);
   cover property (breakpoint_mode && indicator_pin_one);
endmodule

bind decpin_top decpin_chk #(.lag(lag)) u_chk (.clock, .rst_n, .current_privilege_level,
   .model_register_read, .model_register_write, .register_select, .write_data, .read_valid,
   .access_fault, .occurrences_zero, .event_lines, .breakpoint_mode, .indicator_pin_zero,
   .indicator_pin_one, .control_view);

// >>> test/decpin_monitor.sv
/* External monitor tallying indicator pin activity.
   Assumes pins are synchronous to clock. */
`timescale 1ns/1ps
module decpin_monitor (
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // Watched pins
   input  wire logic pin_zero,
   input  wire logic pin_one,
   // High-cycle tallies
   output int        seen_zero,
   output int        seen_one
);
   // High cycles count both pulse and level indication
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         seen_zero <= 0;
         seen_one  <= 0;
      end else begin
         seen_zero <= seen_zero + int'(pin_zero);
         seen_one  <= seen_one + int'(pin_one);
      end
   end
endmodule

// >>> test/tb_top.sv
/* Self-checking bench for decpin_top with a pin monitor.
   Assumes the design's default pin lag of five clocks. */
`timescale 1ns/1ps
module tb_top;
   import decpin_pkg::*;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic [1:0]  priv = 2'h0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [1:0]  sel = 2'h0;
   logic [63:0] wdata = 64'h0;
   logic [1:0]  occ0 = 2'h0;
   logic [1:0]  occ1 = 2'h0;
   logic [63:0] cond0 = 64'h0;
   logic [63:0] cond1 = 64'h0;
   logic [63:0] event_lines = 64'h0;
   logic        breakpoint_mode = 1'b0;
   logic [1:0]  breakpoint_match = 2'h0;
   logic [63:0] rdata;
   logic        rvalid;
   logic        fault;
   logic        pin0;
   logic        pin1;
   logic [31:0] control_view;
   int          seen0;
   int          seen1;
   int          failures = 0;
   int          n_checks = 0;
   integer      seed = 32'hd809;
   logic [63:0] expq[$];

   decpin_top dut (.clock, .rst_n, .current_privilege_level(priv), .model_register_read(rd),
      .model_register_write(wr), .register_select(sel), .write_data(wdata), .read_data(rdata),
      .read_valid(rvalid), .access_fault(fault), .occurrences_zero(occ0), .occurrences_one(occ1),
      .condition_zero_bus(cond0), .condition_one_bus(cond1), .event_lines, .breakpoint_mode,
      .breakpoint_match, .indicator_pin_zero(pin0), .indicator_pin_one(pin1), .control_view);
   decpin_monitor mon (.clock, .rst_n, .pin_zero(pin0), .pin_one(pin1), .seen_zero(seen0),
      .seen_one(seen1));

   always #4 clock = ~clock;

   task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic access(logic r, logic [1:0] s, logic [63:0] d);
      @(negedge clock);
      rd = r;
      wr = !r;
      sel = s;
      wdata = d;
      @(negedge clock);
      rd = 1'b0;
      wr = 1'b0;
   endtask

   task automatic rdreg(logic [1:0] s, logic [63:0] e);
      expq.push_back(e);
      access(1'b1, s, 64'h0);
   endtask

   task automatic final_report();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Oldest expected read is matched against each answer
   always @(negedge clock) begin
      if (rvalid === 1'b1) begin
         check("read_data", rdata, (expq.size() > 0) ? expq.pop_front() : 64'hx);
      end
   end

   initial begin
      #(20000 * 8);
      failures++;
      final_report();
   end

   initial begin
      logic [63:0] v;
      logic [5:0]  c0;
      logic [5:0]  c1;
      logic [2:0]  k;
      logic        en;
      int          m0;
      int          m1;
      repeat (12) @(negedge clock);
      rst_n = 1'b1;
      rdreg(select_control, 64'h0);
      rdreg(select_counter_zero, 64'h0);
      priv = user_privilege;
      access(1'b0, select_control, 64'hffff_ffff);
      check("access_fault", {63'h0, fault}, 64'h1);
      priv = top_privilege;
      rdreg(select_control, 64'h0);
      rdreg(2'h3, 64'h0);
      $display("test privilege done");
      for (int i = 0; i < 4; i++) begin
         v = {$random(seed), $random(seed)};
         access(1'b0, select_control, 64'h0);
         access(1'b0, select_counter_one, v);
         rdreg(select_counter_one, {24'h0, v[39:0]});
         access(1'b0, select_control, v & 64'h03ff_03ff);
         rdreg(select_control, v & 64'h03ff_03ff);
      end
      $display("test registers done");
      for (int i = 0; i < 32; i++) begin
         k = 3'(i / 4);
         c0 = 6'($random(seed));
         c1 = 6'($random(seed));
         access(1'b0, select_control, 64'h0);
         access(1'b0, select_counter_zero, 64'h0);
         access(1'b0, select_counter_one, 64'h0);
         access(1'b0, select_control, {39'h0, k, c1, 7'h0, k, c0});
         m0 = seen0;
         m1 = seen1;
         priv = 2'(i % 4);
         event_lines = (64'h1 << c0) | (64'h1 << c1);
         cond0 = 64'h1 << c0;
         cond1 = 64'h1 << c1;
         occ0 = 2'h2;
         occ1 = 2'h1;
         repeat (4) @(negedge clock);
         en = (k[1] && priv == 2'h3) || (k[0] && priv != 2'h3);
         {occ0, occ1, cond0, cond1, event_lines} = '0;
         priv = top_privilege;
         repeat (8) @(negedge clock);
         rdreg(select_counter_zero, en ? (k[2] ? 64'h4 : 64'h8) : 64'h0);
         rdreg(select_counter_one, en ? 64'h4 : 64'h0);
         check("pin_zero_count", 64'(seen0 - m0), en ? 64'h4 : 64'h0);
         check("pin_one_count", 64'(seen1 - m1), en ? 64'h4 : 64'h0);
      end
      $display("test counting done");
      access(1'b0, select_control, 64'h0);
      access(1'b0, select_counter_zero, 64'hff_ffff_ffff);
      access(1'b0, select_control, 64'h2c0 | 64'(c0));
      event_lines = 64'h1 << c0;
      occ0 = 2'h1;
      @(negedge clock);
      occ0 = 2'h0;
      repeat (3) @(negedge clock);
      check("pin_early", {63'h0, pin0}, 64'h0);
      @(negedge clock);
      check("pin_overflow", {63'h0, pin0}, 64'h1);
      @(negedge clock);
      check("pin_after", {63'h0, pin0}, 64'h0);
      occ0 = 2'h1;
      repeat (3) @(negedge clock);
      occ0 = 2'h0;
      rdreg(select_counter_zero, 64'h3);
      $display("test overflow done");
      breakpoint_mode = 1'b1;
      breakpoint_match = 2'h2;
      repeat (7) @(negedge clock);
      check("breakpoint_pins", {62'h0, pin1, pin0}, 64'h2);
      breakpoint_mode = 1'b0;
      repeat (4) @(negedge clock);
      $display("test breakpoint done");
      final_report();
   end
endmodule
